// file: dv/sync_master_serial_receiver_tb.sv
// self-checking bench for the synchronous master serial receiver
// assumes the package, the design and the slave model are compiled before it
`timescale 1ns/1ns
`default_nettype none
module sync_master_serial_receiver_tb import sync_rx_pkg::*;;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [31:0] PORT = 32'h1 << RSC_PORT_EN;
    localparam logic [31:0] NIN = 32'h1 << RSC_NINTH_EN;
    localparam logic [31:0] SGL = 32'h1 << RSC_SINGLE_EN;
    localparam logic [31:0] CNT = 32'h1 << RSC_CONT_EN;
    logic pclk = 1'b0, presetn = 1'b0; // held low from time zero
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, sdata, shift_clk_out, shift_clk_oe_n, irq;
    logic m_rst_n = 1'b1, nine = 1'b0, sclk, sclk_prev = 1'b0;
    logic [8:0] words [16];
    logic [8:0] cur_word;
    logic [3:0] b;
    int word_cnt, n_edges = 0, n_mismatch = 0, compares = 0, seed, e;

    // the shift clock wire: only the receiver drives it, low when released
    assign sclk = !shift_clk_oe_n & shift_clk_out;
    assign cur_word = words[word_cnt[3:0]];

    always #4 pclk = ~pclk; // 125 MHz

    // count rising shift clock edges seen at the system clock
    always @(posedge pclk) begin
        sclk_prev <= sclk;
        if (sclk && !sclk_prev) n_edges <= n_edges + 1;
    end

    sync_master_serial_receiver uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_data_in_pin(sdata),
        .shift_clk_out(shift_clk_out), .shift_clk_oe_n(shift_clk_oe_n), .irq(irq));

    sync_slave_model slave (.sclk(sclk), .rst_n(m_rst_n), .nine(nine), .word(cur_word),
        .sdata(sdata), .word_cnt(word_cnt));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic timeout_hit;
        n_mismatch++;
        $display("mismatch wait expected answer seen timeout");
        wrap_up;
    endtask

    // one apb transfer; answer taken at the edge where pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) timeout_hit;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    // poll a register bit under a bound; long enough for two words
    task automatic poll(input logic [7:0] a, input int bit_n);
        int i;
        i = 0;
        rd = 32'h0;
        while (rd[bit_n] !== 1'b1) begin
            if (i > 200) timeout_hit;
            i++;
            apb(1'b0, a, 32'h0);
        end
    endtask

    // realign the slave between scenarios while the shift clock is idle
    task automatic mrst;
        m_rst_n <= 1'b0;
        @(posedge pclk);
        m_rst_n <= 1'b1;
        b = word_cnt[3:0];
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 56159;
        for (int i = 0; i < 16; i++) words[i] = 9'($random(seed));
        words[0] = 9'h1a5; // low byte a5 reads the same in either bit order
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // reset state and refusal of an unmapped place
        chk("irq", 32'h0, irq);
        chk("oe_n", 32'h1, shift_clk_oe_n);
        rdchk("rsc", ADDR_RSC, 32'h0);
        rdchk("mode", ADDR_MODE, 32'h0);
        rdchk("baud", ADDR_BAUD, 32'(BAUD_RESET));
        rdchk("istat", ADDR_ISTAT, 32'h0);
        rdchk("ien", ADDR_IEN, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped err", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
        // half period 5 cycles gives the 80 ns shift clock
        apb(1'b1, ADDR_BAUD, 32'h4);
        apb(1'b1, ADDR_MODE, 32'h3);
        apb(1'b1, ADDR_RSC, PORT);
        apb(1'b1, ADDR_IEN, 32'h1);
        rdchk("baud", ADDR_BAUD, 32'h4);
        chk("oe_n", 32'h0, shift_clk_oe_n);
        // single 8-bit word with interrupt
        mrst;
        apb(1'b1, ADDR_RSC, PORT | SGL);
        e = 0;
        while (irq !== 1'b1) begin
            if (e > 400) timeout_hit;
            e++;
            @(posedge pclk);
        end
        rdchk("istat", ADDR_ISTAT, 32'h1);
        apb(1'b0, ADDR_RSC, 32'h0);
        chk("rsc enables", PORT, rd & 32'hf0);
        rdchk("rxbuf", ADDR_RXBUF, 32'(words[b][7:0]));
        repeat (2) @(posedge pclk);
        chk("irq after read", 32'h0, irq);
        e = n_edges;
        repeat (200) @(posedge pclk);
        chk("edges", e, n_edges);
        // single 9-bit word, interrupt masked
        apb(1'b1, ADDR_IEN, 32'h0);
        nine <= 1'b1;
        mrst;
        apb(1'b1, ADDR_RSC, PORT | NIN | SGL);
        poll(ADDR_ISTAT, EV_RX);
        chk("masked irq", 32'h0, irq);
        rdchk("rsc ninth", ADDR_RSC, PORT | NIN | 32'(words[b][8]));
        apb(1'b1, ADDR_ICLR, 32'h1);
        rdchk("istat clr", ADDR_ISTAT, 32'h0);
        rdchk("rxbuf9", ADDR_RXBUF, 32'(words[b][7:0]));
        // wide divisor: high byte counts, half period 261 cycles, one rise in 600
        apb(1'b1, ADDR_MODE, 32'h7);
        apb(1'b1, ADDR_BAUD, 32'h104);
        apb(1'b1, ADDR_RSC, PORT | SGL);
        e = n_edges;
        repeat (600) @(posedge pclk);
        chk("wide edges", e + 1, n_edges);
        apb(1'b1, ADDR_RSC, PORT);
        // narrow again: the high byte left in the divisor must be ignored
        apb(1'b1, ADDR_MODE, 32'h3);
        // both enables: continuous wins, three words back to back
        apb(1'b1, ADDR_IEN, 32'h1);
        nine <= 1'b0;
        mrst;
        apb(1'b1, ADDR_RSC, PORT | SGL | CNT);
        for (int k = 0; k < 3; k++) begin
            poll(ADDR_ISTAT, EV_RX);
            rdchk("rxbuf cont", ADDR_RXBUF, 32'(words[b + 4'(k)][7:0]));
        end
        apb(1'b1, ADDR_RSC, PORT);
        repeat (20) @(posedge pclk);
        apb(1'b1, ADDR_ICLR, 32'h3);
        // overrun: words left unread until reception halts
        apb(1'b1, ADDR_IEN, 32'h2);
        mrst;
        apb(1'b1, ADDR_RSC, PORT | CNT);
        poll(ADDR_RSC, RSC_OVERRUN);
        rdchk("istat ovr", ADDR_ISTAT, 32'h3);
        chk("irq ovr", 32'h1, irq);
        e = n_edges;
        repeat (100) @(posedge pclk);
        chk("halted", e, n_edges);
        rdchk("rxbuf kept", ADDR_RXBUF, 32'(words[b][7:0]));
        apb(1'b1, ADDR_RSC, PORT | CNT);
        apb(1'b0, ADDR_RSC, 32'h0);
        chk("err held", 32'h1, 32'(rd[RSC_OVERRUN]));
        apb(1'b1, ADDR_RSC, PORT);
        apb(1'b0, ADDR_RSC, 32'h0);
        chk("err cleared", 32'h0, 32'(rd[RSC_OVERRUN]));
        apb(1'b1, ADDR_ICLR, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 32'h0, irq);
        wrap_up;
    end
endmodule
`default_nettype wire

// file: dv/sync_slave_model.sv
// behavioural synchronous slave transmitter facing the receiver's shift clock
// assumes sclk is the resolved shift clock wire, idle low, and word is set by the bench
`timescale 1ns/1ns
`default_nettype none
module sync_slave_model (
    // link side
    input wire logic sclk,
    input wire logic rst_n,
    // word to send and its length
    input wire logic nine,
    input wire logic [8:0] word,
    // data back to the receiver
    output logic sdata,
    output var int word_cnt
);
    // ------------------------------------------------------------
    // shift state
    // ------------------------------------------------------------
    int bit_i = 0; // next bit to present, lsb first
    int cnt = 0; // words completed so far
    logic sd = 1'b0; // level shown on the data pin

    assign sdata = sd;
    assign word_cnt = cnt;

    // one process for both shift edges so no variable has two drivers
    always @(posedge sclk or negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            // realign on a word boundary, keep the word count running
            bit_i = 0;
            sd = ~sd;
        end else if (sclk) begin
            sd = word[bit_i];
        end else begin
            // past the sampling edge: show the inverse, never a stale copy
            sd = ~sd;
            bit_i = bit_i + 1;
            if (bit_i == (nine ? 9 : 8)) begin
                bit_i = 0;
                cnt = cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// file: verilog/baud_tick.sv
// baud divisor tick generator for the shift clock
// assumes run is a level from the same clock domain
`timescale 1ns/1ns
`default_nettype none
module baud_tick
    import sync_rx_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic wide,
    input wire logic [15:0] divisor,
    // one pulse per half shift clock period
    output logic tick
);
    // ------------------------------------------------------------
    // half period counter
    // ------------------------------------------------------------
    logic [15:0] cnt_q, cnt_d;  // counts up to the divisor
    logic [15:0] limit;         // narrow divisor uses the low byte only

    always_comb begin
        limit = wide ? divisor : {8'h00, divisor[7:0]};
        tick = run && (cnt_q == limit);
        // held at zero while stopped so the first half period is full length
        if (!run || tick) begin
            cnt_d = 16'h0000;
        end else begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// file: verilog/sync_master_serial_receiver.sv
// synchronous master receive path with apb registers and one interrupt
// assumes the slave changes data after the rising shift clock edge
//
// Functional notes
// RQ1 - clocked mode plus single or continuous starts reception
// RQ2 - data sampled on falling shift clock edge
// RQ3 - single mode receives exactly one word
// RQ4 - continuous mode repeats until its bit clears; here an overrun also halts it while the bit is still set
// RQ5 - both enables set behaves as continuous
// RQ6 - software loads divisor and width before enabling
// RQ7 - software sets clocked, port and master together
// RQ8 - software clears both enables during setup
// RQ9 - completion sets flag, interrupt only when enabled
// RQ10 - ninth bit enable gives nine-bit words
// RQ11 - ninth bit and error readable in status
// RQ12 - buffer read returns low eight bits
// RQ13 - error latched until continuous enable cleared
// RQ14 - software sets global and peripheral enables
// RQ15 - single word end clears single enable, stops clock
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module sync_master_serial_receiver
    import sync_rx_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial link
    input wire logic serial_data_in_pin,
    output logic shift_clk_out,
    output logic shift_clk_oe_n,
    // interrupt
    output logic irq
);
    // ------------------------------------------------------------
    // state declarations
    // ------------------------------------------------------------
    cfg_t cfg_q, cfg_d;                 // software configuration
    logic [15:0] baud_q, baud_d;        // baud_divisor
    logic [EV_BITS-1:0] stat_q, stat_d; // sticky events
    logic [EV_BITS-1:0] ien_q, ien_d;   // event enables
    logic oerr_q, oerr_d;               // latched overrun error
    logic [8:0] rxbuf_q, rxbuf_d;       // last received word
    logic [8:0] shift_q, shift_d;       // incoming bits, lsb first
    logic [3:0] bits_q, bits_d;         // bits taken in this word
    rx_state_t state_q, state_d;        // sequencer
    logic [31:0] rdata_q, rdata_d;      // read data captured at setup
    logic err_q, err_d;                 // unmapped address flag
    logic sync1_q, sync2_q;             // data pin synchroniser
    logic tick;                         // half period pulse
    logic active;                       // reception allowed
    logic done;                         // last bit sampled this cycle
    logic [8:0] word;                   // assembled word at done
    logic wr, rd;                       // completing access strobes

    // decode a mapped address
    function automatic logic mapped(input logic [7:0] a);
        return (a == ADDR_RSC) || (a == ADDR_MODE) || (a == ADDR_BAUD) || (a == ADDR_RXBUF)
            || (a == ADDR_ISTAT) || (a == ADDR_ICLR) || (a == ADDR_IEN);
    endfunction

    // ------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------
    // zero wait: data is captured in setup so the answer comes from flops
    assign pready = 1'b1;
    assign prdata = rdata_q;
    assign pslverr = err_q && psel && penable;
    assign wr = psel && penable && pwrite && !err_q;
    assign rd = psel && penable && !pwrite && !err_q;

    // read mux, evaluated in the setup cycle
    always_comb begin
        rdata_d = rdata_q;
        err_d = err_q;
        if (psel && !penable) begin
            err_d = !mapped(paddr);
            rdata_d = 32'h0000_0000;
            unique case (paddr)
                ADDR_RSC: begin
                    rdata_d[RSC_PORT_EN] = cfg_q.port_en;
                    rdata_d[RSC_NINTH_EN] = cfg_q.ninth_en;
                    rdata_d[RSC_SINGLE_EN] = cfg_q.single_en;
                    rdata_d[RSC_CONT_EN] = cfg_q.cont_en;
                    rdata_d[RSC_OVERRUN] = oerr_q;          // RQ11
                    rdata_d[RSC_NINTH_BIT] = rxbuf_q[8];    // RQ11
                end
                ADDR_MODE: begin
                    rdata_d[MODE_CLOCKED] = cfg_q.clocked;
                    rdata_d[MODE_MASTER] = cfg_q.master;
                    rdata_d[MODE_WIDE] = cfg_q.wide;
                end
                ADDR_BAUD: rdata_d[15:0] = baud_q;
                ADDR_RXBUF: rdata_d[7:0] = rxbuf_q[7:0];    // RQ12
                ADDR_ISTAT: rdata_d[EV_BITS-1:0] = stat_q;
                ADDR_IEN: rdata_d[EV_BITS-1:0] = ien_q;
                default: rdata_d = 32'h0000_0000;           // clear reg and holes read zero
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // ------------------------------------------------------------
    // data pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= serial_data_in_pin;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // shift clock divider
    // ------------------------------------------------------------
    baud_tick u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .run(active || (state_q != ST_IDLE)),
        .wide(cfg_q.wide),
        .divisor(baud_q),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // receive sequencer
    // ------------------------------------------------------------
    // overrun halts the link: the slave would otherwise lose words silently
    assign active = cfg_q.clocked && cfg_q.port_en && cfg_q.master
        && (cfg_q.single_en || cfg_q.cont_en) && !oerr_q;   // RQ1
    // clock is high only in the high phase, straight from state flops
    assign shift_clk_out = state_q[1];
    assign shift_clk_oe_n = !(cfg_q.port_en && cfg_q.clocked && cfg_q.master);

    always_comb begin
        state_d = state_q;
        bits_d = bits_q;
        shift_d = shift_q;
        done = 1'b0;
        // word assembled from the bit sampled now and those shifted before
        word = cfg_q.ninth_en ? {sync2_q, shift_q[8:1]}
            : {1'b0, sync2_q, shift_q[8:2]};                // RQ10
        unique case (state_q)
            ST_IDLE: begin
                bits_d = 4'h0;
                if (active && tick) begin
                    state_d = ST_HIGH;                      // RQ1
                end
            end
            ST_HIGH: begin
                if (tick) begin
                    // falling edge: take the bit
                    shift_d = {sync2_q, shift_q[8:1]};      // RQ2
                    bits_d = bits_q + 4'h1;
                    if (bits_q + 4'h1 == (cfg_q.ninth_en ? BITS_WIDE : BITS_NARROW)) begin
                        done = 1'b1;
                        state_d = ST_IDLE;                  // RQ15
                    end else begin
                        state_d = ST_LOW;
                    end
                end
            end
            ST_LOW: begin
                if (!active) begin
                    state_d = ST_IDLE;                      // aborted by software
                end else if (tick) begin
                    state_d = ST_HIGH;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            bits_q <= 4'h0;
            shift_q <= 9'h000;
        end else begin
            state_q <= state_d;
            bits_q <= bits_d;
            shift_q <= shift_d;
        end
    end

    // ------------------------------------------------------------
    // registers, events and interrupt
    // ------------------------------------------------------------
    always_comb begin
        cfg_d = cfg_q;
        baud_d = baud_q;
        ien_d = ien_q;
        stat_d = stat_q;
        oerr_d = oerr_q;
        rxbuf_d = rxbuf_q;
        if (wr && paddr == ADDR_RSC) begin
            cfg_d.port_en = pwdata[RSC_PORT_EN];
            cfg_d.ninth_en = pwdata[RSC_NINTH_EN];
            cfg_d.single_en = pwdata[RSC_SINGLE_EN];
            cfg_d.cont_en = pwdata[RSC_CONT_EN];
            if (!pwdata[RSC_CONT_EN]) begin
                oerr_d = 1'b0;                              // RQ13
            end
        end
        if (wr && paddr == ADDR_MODE) begin
            cfg_d.clocked = pwdata[MODE_CLOCKED];
            cfg_d.master = pwdata[MODE_MASTER];
            cfg_d.wide = pwdata[MODE_WIDE];
        end
        if (wr && paddr == ADDR_BAUD) begin
            baud_d = pwdata[15:0];
        end
        if (wr && paddr == ADDR_IEN) begin
            ien_d = pwdata[EV_BITS-1:0];
        end
        // clears first so a same-cycle event wins
        if (wr && paddr == ADDR_ICLR) begin
            stat_d = stat_q & ~pwdata[EV_BITS-1:0];
        end
        if (rd && paddr == ADDR_RXBUF) begin
            stat_d[EV_RX] = 1'b0;                           // buffer read consumes the word
        end
        if (done) begin
            if (stat_q[EV_RX] && !(rd && paddr == ADDR_RXBUF)) begin
                oerr_d = 1'b1;                              // unread word kept, new one lost
                stat_d[EV_OVR] = 1'b1;
            end else begin
                rxbuf_d = word;
                stat_d[EV_RX] = 1'b1;                       // RQ9
            end
            if (!cfg_q.cont_en) begin                       // RQ4 RQ5
                cfg_d.single_en = 1'b0;                     // RQ3 RQ15
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= '0;
            baud_q <= BAUD_RESET;
            ien_q <= '0;
            stat_q <= '0;
            oerr_q <= 1'b0;
            rxbuf_q <= 9'h000;
        end else begin
            cfg_q <= cfg_d;
            baud_q <= baud_d;
            ien_q <= ien_d;
            stat_q <= stat_d;
            oerr_q <= oerr_d;
            rxbuf_q <= rxbuf_d;
        end
    end

    // level interrupt from enabled sticky events
    assign irq = |(stat_q & ien_q);                         // RQ9

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_start;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_IDLE && active && tick) |=> (state_q == ST_HIGH && shift_clk_out);
    endproperty
    a_start: assert property (p_start) else $error("reception did not start"); // RQ1

    property p_fall_sample;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_HIGH && tick) |=> !shift_clk_out && shift_q[8] == $past(sync2_q);
    endproperty
    a_fall_sample: assert property (p_fall_sample) else $error("bit not taken on fall"); // RQ2

    property p_single_stop;
        @(posedge pclk) disable iff (!presetn)
        (done && !cfg_q.cont_en) |=> !cfg_q.single_en ##0 (state_q == ST_IDLE)[*2];
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("single word did not stop"); // RQ3

    property p_cont_keep;
        @(posedge pclk) disable iff (!presetn)
        (done && cfg_q.cont_en && !(wr && paddr == ADDR_RSC)) |=> cfg_q.cont_en;
    endproperty
    a_cont_keep: assert property (p_cont_keep) else $error("continuous mode dropped"); // RQ4

    property p_both_cont;
        @(posedge pclk) disable iff (!presetn)
        (done && cfg_q.cont_en && cfg_q.single_en && !wr) |=> cfg_q.single_en;
    endproperty
    a_both_cont: assert property (p_both_cont) else $error("single request not ignored"); // RQ5

    property p_flag_irq;
        @(posedge pclk) disable iff (!presetn)
        $rose(stat_q[EV_RX]) |-> $past(state_q == ST_HIGH) && (irq || !ien_q[EV_RX]);
    endproperty
    a_flag_irq: assert property (p_flag_irq) else $error("flag or interrupt wrong"); // RQ9

    property p_narrow;
        @(posedge pclk) disable iff (!presetn)
        (done && !cfg_q.ninth_en && !stat_q[EV_RX]) |=> rxbuf_q[8] == 1'b0;
    endproperty
    a_narrow: assert property (p_narrow) else $error("ninth bit set in 8-bit word"); // RQ10

    property p_err_hold;
        @(posedge pclk) disable iff (!presetn)
        (oerr_q && !(wr && paddr == ADDR_RSC)) |=> oerr_q && !active;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error not held"); // RQ13

endmodule
`default_nettype wire

// file: verilog/sync_rx_pkg.sv
// package for the synchronous master serial receiver
// assumes an apb bus with 32-bit data and byte addresses on word boundaries
package sync_rx_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RSC = 8'h00;    // receive_status_control
    localparam logic [7:0] ADDR_MODE = 8'h04;   // clocked mode, master, divisor width
    localparam logic [7:0] ADDR_BAUD = 8'h08;   // baud_divisor
    localparam logic [7:0] ADDR_RXBUF = 8'h0c;  // receive_buffer
    localparam logic [7:0] ADDR_ISTAT = 8'h10;  // sticky event status
    localparam logic [7:0] ADDR_ICLR = 8'h14;   // write one to clear status
    localparam logic [7:0] ADDR_IEN = 8'h18;    // event enables

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int RSC_PORT_EN = 7;     // serial_port_enable
    localparam int RSC_NINTH_EN = 6;    // ninth_bit_receive_enable
    localparam int RSC_SINGLE_EN = 5;   // single_receive_enable
    localparam int RSC_CONT_EN = 4;     // continuous_receive_enable
    localparam int RSC_OVERRUN = 1;     // overrun error, read only
    localparam int RSC_NINTH_BIT = 0;   // received ninth bit, read only
    localparam int MODE_CLOCKED = 0;    // clocked_mode_select
    localparam int MODE_MASTER = 1;     // clock_source_master
    localparam int MODE_WIDE = 2;       // wide_divisor_select
    localparam int EV_RX = 0;           // receive_flag / receive_irq_enable
    localparam int EV_OVR = 1;          // overrun event
    localparam int EV_BITS = 2;         // number of events

    // ------------------------------------------------------------
    // word sizes and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] BITS_NARROW = 4'h8;
    localparam logic [3:0] BITS_WIDE = 4'h9;
    localparam logic [15:0] BAUD_RESET = 16'h0000;

    // software configuration held together
    typedef struct packed {
        logic port_en;
        logic ninth_en;
        logic single_en;
        logic cont_en;
        logic clocked;
        logic master;
        logic wide;
    } cfg_t;

    // receive sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HIGH = 3'b010,
        ST_LOW = 3'b100
    } rx_state_t;

endpackage
